//--- pkg/trne_pkg.sv
// Functional notes
// - Negate writes two's complement back in place.
// - Table read copies program byte into latch.
// - Table pointer is 21-bit byte address.
// - Pointer bit zero selects low/high word byte.
// - Opcode low bits pick pointer update mode.
// - Post modes read first, then step pointer.
// - Pre-increment steps pointer, then reads.
// - Table read takes two instruction cycles.
package trne_pkg;

    // Widths of the data paths.
    localparam int PTR_W   = 21;   // Table pointer width in bits.
    localparam int WORD_W  = 16;   // Program memory word width.
    localparam int BYTE_W  = 8;    // Data byte width.
    localparam int BANK_W  = 4;    // Data bank selector width.
    localparam int FADDR_W = 12;   // Full data memory address width.
    localparam int STAT_W  = 5;    // Status flags: N, OV, Z, DC, C.

    // Status flag positions inside the status vector.
    localparam int ST_C  = 0;
    localparam int ST_DC = 1;
    localparam int ST_Z  = 2;
    localparam int ST_OV = 3;
    localparam int ST_N  = 4;

    // Opcode patterns.
    localparam logic [6:0]  OPC_NEGATE  = 7'h36;   // Upper seven opcode bits 0110110.
    localparam logic [13:0] OPC_TBLREAD = 14'h0002; // Upper fourteen bits 0000_0000_0000_10.
    localparam logic [15:0] OPC_IDLE    = 16'h0000; // Single-word idle code.
    localparam logic [3:0]  OPC_IDLE_HI = 4'hf;    // Second idle form, any low bits.

    // Access bank split point and the bank used above it.
    localparam logic [7:0]        ACCESS_SPLIT = 8'h80;
    localparam logic [BANK_W-1:0] ACCESS_HI_BANK = 4'hf;

    // Pointer update modes carried in the opcode low bits.
    localparam logic [1:0] TM_KEEP     = 2'h0;
    localparam logic [1:0] TM_POST_INC = 2'h1;
    localparam logic [1:0] TM_POST_DEC = 2'h2;
    localparam logic [1:0] TM_PRE_INC  = 2'h3;

    // Quarter-cycle codes, one-hot.
    localparam logic [3:0] QTR_1 = 4'h1;
    localparam logic [3:0] QTR_2 = 4'h2;
    localparam logic [3:0] QTR_3 = 4'h4;
    localparam logic [3:0] QTR_4 = 4'h8;

    // Values after reset.
    localparam logic [PTR_W-1:0]  PTR_RESET   = 21'h000000;
    localparam logic [BYTE_W-1:0] LATCH_RESET = 8'h00;

    // Execution states, one-hot.
    typedef enum logic [3:0] {
        ST_IDLE  = 4'h1,
        ST_NEG   = 4'h2,
        ST_TBL_A = 4'h4,
        ST_TBL_B = 4'h8
    } trne_state_t;

    // Complete state of the execution unit.
    typedef struct packed {
        trne_state_t              fsm;         // Current instruction step.
        logic                     nop_run;     // Idle instruction in progress.
        logic [1:0]               mode;        // Latched pointer update mode.
        logic [PTR_W-1:0]         ptr;         // Table byte pointer.
        logic [BYTE_W-1:0]        latch;       // Table holding latch.
        logic [FADDR_W-1:0]       file_addr;   // Data memory address.
        logic                     file_rd;     // Data memory read strobe.
        logic                     file_wr;     // Data memory write strobe.
        logic [BYTE_W-1:0]        file_wdata;  // Data memory write data.
        logic [PTR_W-2:0]         pmem_addr;   // Program word address.
        logic                     pmem_rd;     // Program memory read strobe.
        logic                     status_wr;   // Status update strobe.
        logic [STAT_W-1:0]        status;      // Status flags to write.
        logic                     done;        // Instruction retire pulse.
    } trne_regs_t;

endpackage

//--- rtl/trne_quarter.sv
`timescale 1ns/1ps
module trne_quarter
    import trne_pkg::*;
(
    input  wire logic       i_clk,
    input  wire logic       i_resetn,
    output logic [3:0]      o_quarter
);

    // Rotating one-hot phase; every four clocks make one instruction cycle.
    logic [3:0] next_quarter;

    // Next phase is the current one rotated left by one.
    always_comb begin
        next_quarter = {o_quarter[2:0], o_quarter[3]};
    end

    // Phase register; reset parks it in the first quarter.
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_quarter <= QTR_1;
        end else begin
            o_quarter <= next_quarter;
        end
    end

endmodule // trne_quarter

//--- rtl/trne_exec.sv
`timescale 1ns/1ps
module trne_exec
    import trne_pkg::*;
(
    input  wire logic                I_REF_CLK,       // Core clock.
    input  wire logic                I_RESETN,        // Synchronous reset, active low.
    input  wire logic                I_INSTR_VALID,   // Opcode offered in quarter one.
    input  wire logic [WORD_W-1:0]   I_OPCODE,        // Instruction word.
    input  wire logic [BANK_W-1:0]   I_BANK_SEL,      // Data bank selector from the core.
    input  wire logic [BYTE_W-1:0]   I_FILE_RDATA,    // Data memory read data.
    input  wire logic [WORD_W-1:0]   I_PMEM_RDATA,    // Program memory word read data.
    input  wire logic                I_PTR_WR,        // Core loads the table pointer.
    input  wire logic [PTR_W-1:0]    I_PTR_WDATA,     // Value for the table pointer.
    output logic [3:0]               O_QUARTER,       // Current quarter, one-hot.
    output logic                     O_BUSY,          // An instruction is executing.
    output logic                     O_DONE,          // Instruction retired.
    output logic [FADDR_W-1:0]       O_FILE_ADDR,     // Data memory address.
    output logic                     O_FILE_RD,       // Data memory read strobe.
    output logic                     O_FILE_WR,       // Data memory write strobe.
    output logic [BYTE_W-1:0]        O_FILE_WDATA,    // Data memory write data.
    output logic                     O_STATUS_WR,     // Status flags update strobe.
    output logic [STAT_W-1:0]        O_STATUS,        // Status flags N, OV, Z, DC, C.
    output logic                     O_PMEM_RD,       // Program memory read strobe.
    output logic [PTR_W-2:0]         O_PMEM_ADDR,     // Program memory word address.
    output logic [PTR_W-1:0]         O_TABLE_PTR,     // Table byte pointer.
    output logic [BYTE_W-1:0]        O_TABLE_LATCH    // Table holding latch.
);

    // Registered state and its next value.
    trne_regs_t r;
    trne_regs_t next_r;

    // Quarter phase from the phase generator.
    logic [3:0] quarter;

    // Decoded opcode classes.
    logic dec_neg;
    logic dec_tbl;
    logic dec_idle;
    logic accept;

    // Negate datapath results.
    logic [BYTE_W-1:0] neg_val;

    // Program byte picked out of the returned word.
    logic [BYTE_W-1:0] pm_byte;

    // Builds the full data address from the operand and the access bit.
    function automatic logic [FADDR_W-1:0] file_address(
        input logic [BYTE_W-1:0] f,
        input logic              a,
        input logic [BANK_W-1:0] bank
    );
        logic [BANK_W-1:0] sel;
        sel = bank;
        if (!a) begin
            sel = (f < ACCESS_SPLIT) ? '0 : ACCESS_HI_BANK;
        end
        return {sel, f};
    endfunction

    // Picks one byte of a program word from the pointer low bit.
    function automatic logic [BYTE_W-1:0] word_byte(
        input logic [WORD_W-1:0] w,
        input logic              hi
    );
        return hi ? w[WORD_W-1:BYTE_W] : w[BYTE_W-1:0];
    endfunction

    // Phase generator shared by every instruction step.
    trne_quarter u_quarter (
        .i_clk     (I_REF_CLK),
        .i_resetn  (I_RESETN),
        .o_quarter (quarter)
    );

    // Opcode classification; only accepted in quarter one while idle.
    always_comb begin
        dec_neg  = (I_OPCODE[15:9] == OPC_NEGATE);
        dec_tbl  = (I_OPCODE[15:2] == OPC_TBLREAD);
        dec_idle = (I_OPCODE == OPC_IDLE) || (I_OPCODE[15:12] == OPC_IDLE_HI);
        accept   = I_INSTR_VALID && (quarter == QTR_1) && (r.fsm == ST_IDLE);
    end

    // Two's complement of the operand, inverted then incremented.
    always_comb begin
        neg_val = BYTE_W'(~I_FILE_RDATA + 8'h01);
        pm_byte = word_byte(I_PMEM_RDATA, r.ptr[0]);
    end

    // Next-state logic for the whole unit.
    always_comb begin
        next_r           = r;
        next_r.done      = 1'b0;
        next_r.file_rd   = 1'b0;
        next_r.file_wr   = 1'b0;
        next_r.status_wr = 1'b0;
        next_r.pmem_rd   = 1'b0;
        unique case (r.fsm)
            ST_IDLE: begin
                // Pointer loads from the core are taken only between instructions.
                if (I_PTR_WR && !accept) begin
                    next_r.ptr = I_PTR_WDATA;
                end
                if (accept && dec_neg) begin
                    // Decode quarter: address and read strobe shown in quarter two.
                    next_r.fsm       = ST_NEG;
                    next_r.file_addr = file_address(I_OPCODE[7:0], I_OPCODE[8], I_BANK_SEL);
                    next_r.file_rd   = 1'b1;
                end else if (accept && dec_tbl) begin
                    // First cycle of the table read decodes, latches the mode and ends with any pre-increment.
                    next_r.fsm  = ST_TBL_A;
                    next_r.mode = I_OPCODE[1:0];
                end else if (accept && dec_idle) begin
                    // Idle instruction only waits out its own cycle.
                    next_r.fsm     = ST_NEG;
                    next_r.nop_run = 1'b1;
                end
            end
            ST_NEG: begin
                // Shared single-cycle path for negate and the idle instruction.
                if (quarter == QTR_3 && !r.nop_run) begin
                    // Process in quarter three; write shows in quarter four.
                    next_r.file_wr        = 1'b1;
                    next_r.file_wdata     = neg_val;
                    next_r.status_wr      = 1'b1;
                    next_r.status[ST_N]   = neg_val[BYTE_W-1];
                    next_r.status[ST_Z]   = (neg_val == 8'h00);
                    next_r.status[ST_OV]  = (I_FILE_RDATA == 8'h80);
                    next_r.status[ST_C]   = (I_FILE_RDATA == 8'h00);
                    next_r.status[ST_DC]  = (I_FILE_RDATA[3:0] == 4'h0);
                end
                if (quarter == QTR_4) begin
                    // Cycle ends; nothing of the idle instruction is written.
                    next_r.fsm     = ST_IDLE;
                    next_r.nop_run = 1'b0;
                    next_r.done    = 1'b1;
                end
            end
            ST_TBL_A: begin
                // Pre-increment takes place before the read cycle begins.
                if (quarter == QTR_4) begin
                    next_r.fsm = ST_TBL_B;
                    if (r.mode == TM_PRE_INC) begin
                        next_r.ptr = PTR_W'(r.ptr + 21'h000001);
                    end
                end
            end
            ST_TBL_B: begin
                if (quarter == QTR_1) begin
                    // Program memory is read in quarter two at the word address.
                    next_r.pmem_rd   = 1'b1;
                    next_r.pmem_addr = r.ptr[PTR_W-1:1];
                end else if (quarter == QTR_3) begin
                    // Latch written so its new value stands in quarter four.
                    next_r.latch = pm_byte;
                end else if (quarter == QTR_4) begin
                    // Post modes step the pointer only after the read.
                    unique case (r.mode)
                        TM_POST_INC: next_r.ptr = PTR_W'(r.ptr + 21'h000001);
                        TM_POST_DEC: next_r.ptr = PTR_W'(r.ptr - 21'h000001);
                        TM_KEEP:     next_r.ptr = r.ptr;
                        TM_PRE_INC:  next_r.ptr = r.ptr;
                    endcase
                    next_r.fsm  = ST_IDLE;
                    next_r.done = 1'b1;
                end
            end
        endcase
    end

    // State register with synchronous reset.
    always_ff @(posedge I_REF_CLK) begin
        if (!I_RESETN) begin
            r            <= '0;
            r.fsm        <= ST_IDLE;
            r.ptr        <= PTR_RESET;
            r.latch      <= LATCH_RESET;
        end else begin
            r            <= next_r;
        end
    end

    // Outputs come from the state and phase flip-flops; O_BUSY is decoded from the state.
    always_comb begin
        O_QUARTER     = quarter;
        O_BUSY        = (r.fsm != ST_IDLE);
        O_DONE        = r.done;
        O_FILE_ADDR   = r.file_addr;
        O_FILE_RD     = r.file_rd;
        O_FILE_WR     = r.file_wr;
        O_FILE_WDATA  = r.file_wdata;
        O_STATUS_WR   = r.status_wr;
        O_STATUS      = r.status;
        O_PMEM_RD     = r.pmem_rd;
        O_PMEM_ADDR   = r.pmem_addr;
        O_TABLE_PTR   = r.ptr;
        O_TABLE_LATCH = r.latch;
    end

endmodule // trne_exec

//--- testbench/trne_pmem_model.sv
`timescale 1ns/1ps
// Program and data memory seen by the execution unit, one-cycle read latency.
module trne_pmem_model
    import trne_pkg::*;
(
    input  wire logic              i_clk,
    input  wire logic              i_pmem_rd,
    input  wire logic [PTR_W-2:0]  i_pmem_addr,
    input  wire logic              i_file_rd,
    input  wire logic [BYTE_W-1:0] i_file_byte,
    output logic      [WORD_W-1:0] o_pmem_rdata,
    output logic      [BYTE_W-1:0] o_file_rdata
);
    // Idle buses start from a known pattern.
    initial begin
        o_pmem_rdata = 16'h0f0f;
        o_file_rdata = 8'h5a;
    end
    // Data is valid one cycle after the strobe, then the lines toggle so stale reads show.
    always @(posedge i_clk) begin
        o_pmem_rdata <= i_pmem_rd ? {i_pmem_addr[7:0] ^ 8'ha5, i_pmem_addr[7:0]} : ~o_pmem_rdata;
        o_file_rdata <= i_file_rd ? i_file_byte : ~o_file_rdata;
    end
endmodule // trne_pmem_model

//--- testbench/trne_exec_chk.sv
`timescale 1ns/1ps
// Timing and data relations at the execution unit ports.
module trne_exec_chk
    import trne_pkg::*;
(
    input wire logic              I_REF_CLK,
    input wire logic              I_RESETN,
    input wire logic              I_INSTR_VALID,
    input wire logic [WORD_W-1:0] I_OPCODE,
    input wire logic [BYTE_W-1:0] I_FILE_RDATA,
    input wire logic [WORD_W-1:0] I_PMEM_RDATA,
    input wire logic [3:0]        O_QUARTER,
    input wire logic              O_BUSY,
    input wire logic              O_DONE,
    input wire logic [FADDR_W-1:0] O_FILE_ADDR,
    input wire logic              O_FILE_RD,
    input wire logic              O_FILE_WR,
    input wire logic [BYTE_W-1:0] O_FILE_WDATA,
    input wire logic              O_STATUS_WR,
    input wire logic              O_PMEM_RD,
    input wire logic [PTR_W-2:0]  O_PMEM_ADDR,
    input wire logic [PTR_W-1:0]  O_TABLE_PTR,
    input wire logic [BYTE_W-1:0] O_TABLE_LATCH
);
    logic acc; // An opcode is taken at this edge.
    logic tbl; // The taken opcode is a table read.
    assign acc = I_INSTR_VALID && O_QUARTER == QTR_1 && !O_BUSY;
    assign tbl = acc && I_OPCODE[15:2] == OPC_TBLREAD;
    default clocking @(posedge I_REF_CLK); endclocking
    default disable iff (!I_RESETN);
    // Negate: read in quarter two, write and flags in quarter four, retire after.
    sequence neg_steps;
        ##1 O_FILE_RD ##2 (O_FILE_WR && O_STATUS_WR) ##1 O_DONE;
    endsequence
    // Table read: busy for two instruction cycles, memory strobe in the second one's quarter two.
    sequence tbl_steps;
        ##1 O_BUSY[*4] ##1 (O_BUSY && O_PMEM_RD) ##1 O_BUSY[*2] ##1 O_DONE;
    endsequence
    a_neg_steps: assert property (acc && I_OPCODE[15:9] == OPC_NEGATE |-> neg_steps)
        else $error("negate step order wrong");
    a_neg_value: assert property (O_FILE_WR |-> O_FILE_WDATA == BYTE_W'(~$past(I_FILE_RDATA) + 1)
        && O_FILE_ADDR == $past(O_FILE_ADDR, 2))
        else $error("negate result or address wrong");
    a_tbl_timing: assert property (tbl |-> tbl_steps)
        else $error("table read timing wrong");
    a_pmem_addr: assert property (O_PMEM_RD |-> O_PMEM_ADDR == O_TABLE_PTR[PTR_W-1:1])
        else $error("program address not from pointer");
    a_latch_byte: assert property ($past(O_PMEM_RD, 2) |-> O_TABLE_LATCH == ($past(O_TABLE_PTR[0], 2)
        ? $past(I_PMEM_RDATA[15:8]) : $past(I_PMEM_RDATA[7:0])))
        else $error("latch byte wrong");
    a_latch_hold: assert property ($changed(O_TABLE_LATCH) && $past(I_RESETN)
        |-> $past(O_PMEM_RD, 2))
        else $error("latch changed without a read");
    a_read_point: assert property (tbl |-> ##5 O_TABLE_PTR == $past(O_TABLE_PTR, 5)
        + PTR_W'($past(I_OPCODE[1:0], 5) == TM_PRE_INC))
        else $error("pointer wrong at read time");
    a_ptr_step: assert property (tbl |-> ##9 O_TABLE_PTR == $past(O_TABLE_PTR, 9)
        + (($past(I_OPCODE[1:0], 9) == TM_KEEP) ? '0
        : ($past(I_OPCODE[1:0], 9) == TM_POST_DEC) ? '1 : PTR_W'(1)))
        else $error("pointer final value wrong");
    a_idle_quiet: assert property (acc && (I_OPCODE == OPC_IDLE || I_OPCODE[15:12] == OPC_IDLE_HI)
        |-> ##1 (!(O_FILE_WR || O_STATUS_WR || O_PMEM_RD))[*3] ##1 O_DONE)
        else $error("idle instruction had an effect");
endmodule // trne_exec_chk

bind trne_exec trne_exec_chk u_trne_exec_chk (.I_REF_CLK(I_REF_CLK), .I_RESETN(I_RESETN),
    .I_INSTR_VALID(I_INSTR_VALID), .I_OPCODE(I_OPCODE), .I_FILE_RDATA(I_FILE_RDATA),
    .I_PMEM_RDATA(I_PMEM_RDATA), .O_QUARTER(O_QUARTER), .O_BUSY(O_BUSY), .O_DONE(O_DONE),
    .O_FILE_ADDR(O_FILE_ADDR), .O_FILE_RD(O_FILE_RD), .O_FILE_WR(O_FILE_WR),
    .O_FILE_WDATA(O_FILE_WDATA), .O_STATUS_WR(O_STATUS_WR), .O_PMEM_RD(O_PMEM_RD),
    .O_PMEM_ADDR(O_PMEM_ADDR), .O_TABLE_PTR(O_TABLE_PTR), .O_TABLE_LATCH(O_TABLE_LATCH));

//--- testbench/trne_exec_tb_top.sv
`timescale 1ns/1ps
// Drives negate, table read and idle instructions and checks their effects.
module trne_exec_tb_top
    import trne_pkg::*;
;
    logic clk, resetn, valid, ptr_wr;
    logic [15:0] op, pmem_rdata;
    logic [3:0] bank, quarter;
    logic [7:0] fbyte, file_rdata, wdata, latch;
    logic [20:0] ptr_wd, ptr;
    logic [19:0] pmem_addr;
    logic [11:0] faddr;
    logic [4:0] status;
    logic busy, done, file_rd, file_wr, status_wr, pmem_rd;
    int err_total, comparisons;

    trne_exec u_trne_exec (.I_REF_CLK(clk), .I_RESETN(resetn), .I_INSTR_VALID(valid),
        .I_OPCODE(op), .I_BANK_SEL(bank), .I_FILE_RDATA(file_rdata), .I_PMEM_RDATA(pmem_rdata),
        .I_PTR_WR(ptr_wr), .I_PTR_WDATA(ptr_wd), .O_QUARTER(quarter), .O_BUSY(busy),
        .O_DONE(done), .O_FILE_ADDR(faddr), .O_FILE_RD(file_rd), .O_FILE_WR(file_wr),
        .O_FILE_WDATA(wdata), .O_STATUS_WR(status_wr), .O_STATUS(status), .O_PMEM_RD(pmem_rd),
        .O_PMEM_ADDR(pmem_addr), .O_TABLE_PTR(ptr), .O_TABLE_LATCH(latch));
    trne_pmem_model u_trne_pmem_model (.i_clk(clk), .i_pmem_rd(pmem_rd), .i_pmem_addr(pmem_addr),
        .i_file_rd(file_rd), .i_file_byte(fbyte), .o_pmem_rdata(pmem_rdata),
        .o_file_rdata(file_rdata));

    // Prints the counts and the verdict, then ends the run.
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // Compares one value and reports a mismatch at once.
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (e !== g) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Offers an opcode until it is taken in quarter one while idle.
    task automatic issue(input logic [15:0] o);
        valid <= 1'b1;
        op <= o;
        do @(posedge clk); while (!(quarter === QTR_1 && busy === 1'b0));
        valid <= 1'b0;
    endtask
    // Counts edges until the retire pulse is seen.
    task automatic wait_done(output int n);
        n = 0;
        do begin @(posedge clk); n++; end while (done !== 1'b1);
    endtask
    // Negate of byte d at file f; checks result, address and flags.
    task automatic neg(input logic a, input logic [3:0] b, input logic [7:0] f,
                       input logic [7:0] d, input logic [11:0] ea);
        logic [7:0] w, r;
        logic [4:0] s;
        logic [11:0] ad;
        int n;
        r = ~d + 8'h01;
        bank <= b;
        fbyte <= d;
        issue({OPC_NEGATE, a, f});
        n = 0;
        do begin
            @(posedge clk);
            n++;
            if (file_wr === 1'b1) begin w = wdata; s = status; ad = faddr; end
        end while (done !== 1'b1);
        chk("neg data", r, w);
        chk("neg addr", ea, ad);
        chk("neg flags", {r[7], d == 8'h80, r == 8'h00, d[3:0] == 4'h0, d == 8'h00}, s);
        chk("neg cycles", 32'd4, n);
    endtask
    // Table read from pointer p0 in mode m; checks latch, pointer and duration.
    task automatic tbl(input logic [20:0] p0, input logic [1:0] m);
        logic [20:0] ra, pe;
        int n;
        ptr_wr <= 1'b1;
        ptr_wd <= p0;
        @(posedge clk);
        ptr_wr <= 1'b0;
        ra = p0 + 21'(m == TM_PRE_INC);
        pe = (m == TM_KEEP) ? p0 : (m == TM_POST_DEC) ? p0 - 21'h1 : p0 + 21'h1;
        issue({OPC_TBLREAD, m});
        wait_done(n);
        chk("latch", ra[0] ? ra[8:1] ^ 8'ha5 : ra[8:1], latch);
        chk("pointer", pe, ptr);
        chk("tbl cycles", 32'd8, n);
    endtask
    // Idle opcode must leave pointer and latch alone and retire in one cycle.
    task automatic idle(input logic [15:0] o);
        logic [20:0] p;
        logic [7:0] l;
        int n;
        p = ptr;
        l = latch;
        issue(o);
        wait_done(n);
        chk("idle cycles", 32'd4, n);
        chk("idle ptr", p, ptr);
        chk("idle latch", l, latch);
    endtask

    // Free-running 200 MHz clock.
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // Cuts a hang short well beyond the expected run of about 100 cycles.
    initial begin
        repeat (3000) @(posedge clk);
        err_total++;
        summarize();
    end
    // Main sequence.
    initial begin
        resetn = 1'b0; valid = 1'b0; op = 16'h0000; bank = 4'h0;
        fbyte = 8'h00; ptr_wr = 1'b0; ptr_wd = 21'h000000;
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        neg(1'b0, 4'h5, 8'h3a, 8'h3a, 12'h03a);
        neg(1'b1, 4'h5, 8'h3a, 8'h00, 12'h53a);
        neg(1'b0, 4'h2, 8'h90, 8'h80, 12'hf90);
        neg(1'b1, 4'hc, 8'hff, 8'h01, 12'hcff);
        tbl(21'h00a356, TM_POST_INC);
        tbl(21'h1fffff, TM_PRE_INC);
        tbl(21'h000000, TM_POST_DEC);
        tbl(21'h01a357, TM_KEEP);
        idle(OPC_IDLE);
        idle(16'hf123);
        summarize();
    end
endmodule // trne_exec_tb_top
